// File: verilog/csu_top.sv
// control speculation unit: register files with deferred-fault flags, token
// propagation, check, compare, spill and fill, driven over an avalon slave
// assumes one clock, synchronous reset, and a master that holds its request
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "csu_defines.svh"

module csu_top (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic [5:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             CONSUME_FAULT
);
   import csu_pkg::*;

   csu_state_s s_q;
   csu_state_s s_d;

   // ==================================================
   // helpers

   // byte-enable merge of a bus write into a 32-bit field
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // the single reserved float pattern that stands for a token
   function automatic logic is_tok(input logic [81:0] v);
      return v == `CSU_FR_TOKEN;
   endfunction : is_tok

   // integer value in float register format
   function automatic logic [81:0] int_fr(input logic [63:0] v);
      return {1'b0, `CSU_FR_EXP_INT, v};
   endfunction : int_fr

   // write two predicates; predicate 0 always reads one
   function automatic logic [15:0] pset(input logic [15:0] p,
                                        input csu_cmd_s    c,
                                        input logic        v1,
                                        input logic        v2);
      logic [15:0] r;
      r       = p;
      r[c.p1] = v1;
      r[c.p2] = v2;
      r[0]    = 1'b1;
      return r;
   endfunction : pset

   // compare outcome: a token source clears (normal) or keeps (or type)
   function automatic logic [15:0] pcmp(input logic [15:0] p,
                                        input csu_cmd_s    c,
                                        input logic        tok,
                                        input logic        res);
      logic [15:0] r;
      r = p;
      if (tok) begin
         if (!c.ctype) begin
            r = pset(p, c, 1'b0, 1'b0);
         end
      end else if (!c.ctype) begin
         r = pset(p, c, res, !res);
      end else if (res) begin
         r = pset(p, c, 1'b1, 1'b1);
      end
      return r;
   endfunction : pcmp

   // register read-back
   function automatic logic [31:0] rd(input csu_state_s s, input logic [5:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         `CSU_OFS_CMD:     r = s.cmd;
         `CSU_OFS_ADDR:    r = s.addr;
         `CSU_OFS_OPD_LO:  r = s.opd[31:0];
         `CSU_OFS_OPD_HI:  r = s.opd[63:32];
         `CSU_OFS_OPD_EX:  r = {14'h0000, s.opd[81:64]};
         `CSU_OFS_STAT:    r = {28'h0000000, s.mem_we, s.taken, s.lfault, s.cfault};
         `CSU_OFS_RES_LO:  r = s.res[31:0];
         `CSU_OFS_RES_HI:  r = s.res[63:32];
         `CSU_OFS_RES_EX:  r = {14'h0000, s.res[81:64]};
         `CSU_OFS_FLAG_COLLECTION_REG_LO: r = s.flag_collection_reg[31:0];
         `CSU_OFS_FLAG_COLLECTION_REG_HI: r = s.flag_collection_reg[63:32];
         `CSU_OFS_PRED:    r = {16'h0000, s.pred[15:1], 1'b1};
         `CSU_OFS_VSEL:    r = {28'h0000000, s.vsel};
         `CSU_OFS_VLO:     r = s.gr_dat[s.vsel][31:0];
         `CSU_OFS_VHI:     r = s.gr_dat[s.vsel][63:32];
         `CSU_OFS_VFLG:    r = {31'h00000000, s.gr_flag[s.vsel]};
         default:          r = 32'h0000_0000;
      endcase
      return r;
   endfunction : rd

   // ==================================================
   // next state: bus handshake, register writes, execution of a command
   always_comb begin
      csu_cmd_s    c;
      logic        acc;
      logic [31:0] wv;
      logic [63:0] d64;
      logic [63:0] g1;
      logic [63:0] g2;
      logic        f1;
      logic        f2;
      logic [81:0] fr1;
      logic [81:0] fr2;
      logic [5:0]  idx;
      logic [2:0]  fd;
      c   = csu_cmd_s'(AVS_WRITEDATA);
      acc = !s_q.wt;
      wv  = 32'h0000_0000;
      d64 = s_q.opd[63:0];
      g1  = 64'h0;
      g2  = 64'h0;
      f1  = 1'b0;
      f2  = 1'b0;
      fr1 = 82'h0;
      fr2 = 82'h0;
      idx = s_q.addr[`CSU_IDX_HI:`CSU_IDX_LO];
      fd  = 3'h0;
      s_d = s_q;

      // one wait cycle per request; the answer comes on the second edge
      s_d.wt = !((AVS_READ || AVS_WRITE) && s_q.wt);
      if (AVS_READ && s_q.wt) begin
         s_d.rdata = rd(s_q, AVS_ADDRESS);
      end

      if (AVS_WRITE && acc) begin
         unique case (AVS_ADDRESS)
            `CSU_OFS_CMD: begin
               wv  = be_merge(s_q.cmd, AVS_WRITEDATA, AVS_BYTEENABLE);
               c   = csu_cmd_s'(wv);
               g1  = s_q.gr_dat[c.s1];
               g2  = s_q.gr_dat[c.s2];
               f1  = s_q.gr_flag[c.s1];
               f2  = s_q.gr_flag[c.s2];
               fr1 = s_q.fr[c.s1[2:0]];
               fr2 = s_q.fr[c.s2[2:0]];
               fd  = c.dst[2:0];
               s_d.cmd    = c;
               s_d.taken  = 1'b0;
               s_d.mem_we = 1'b0;
               unique case (c.op)
                  OP_LD: begin
                     // non-speculative: fault is raised, destination kept
                     if (c.flt) begin
                        s_d.lfault = 1'b1;
                     end else begin
                        s_d.gr_dat[c.dst]  = d64;
                        s_d.gr_flag[c.dst] = 1'b0;
                     end
                  end
                  OP_LD_S: begin
                     // token data reads zero so that the spill choice stays valid
                     s_d.gr_dat[c.dst]  = c.flt ? 64'h0 : d64;
                     s_d.gr_flag[c.dst] = c.flt;
                  end
                  OP_LDF: begin
                     if (c.flt) begin
                        s_d.lfault = 1'b1;
                     end else begin
                        s_d.fr[fd] = int_fr(d64);
                     end
                  end
                  OP_LDF_S: begin
                     s_d.fr[fd] = c.flt ? `CSU_FR_TOKEN : int_fr(d64);
                  end
                  OP_LDFP: begin
                     if (c.flt) begin
                        s_d.lfault = 1'b1;
                     end else begin
                        s_d.fr[fd]        = int_fr({32'h0, d64[31:0]});
                        s_d.fr[fd + 3'h1] = int_fr({32'h0, d64[63:32]});
                     end
                  end
                  OP_LDFP_S: begin
                     // both targets of a faulting pair carry the token
                     s_d.fr[fd]        = c.flt ? `CSU_FR_TOKEN : int_fr({32'h0, d64[31:0]});
                     s_d.fr[fd + 3'h1] = c.flt ? `CSU_FR_TOKEN : int_fr({32'h0, d64[63:32]});
                  end
                  OP_ADD: begin
                     // computed in full even for tokens; the flag is what counts
                     s_d.gr_dat[c.dst]  = g1 + g2;
                     s_d.gr_flag[c.dst] = f1 | f2;
                  end
                  OP_ST: begin
                     // store changes memory, so a token source cannot be deferred
                     if (f1 || f2) begin
                        s_d.cfault = 1'b1;
                     end else begin
                        s_d.mem_we = 1'b1;
                        s_d.res    = {18'h00000, g2};
                     end
                  end
                  OP_CHK: begin
                     s_d.taken        = f1;
                     s_d.res[63:0]    = {32'h0, f1 ? s_q.addr + s_q.opd[31:0] : s_q.addr + `CSU_BUNDLE};
                     s_d.res[81:64]   = 18'h00000;
                  end
                  OP_CMP: begin
                     s_d.pred = pcmp(s_q.pred, c, f1 | f2,
                                     c.w32 ? g1[31:0] == g2[31:0] : g1 == g2);
                  end
                  OP_FCMP: begin
                     s_d.pred = pcmp(s_q.pred, c, is_tok(fr1) | is_tok(fr2), fr1 == fr2);
                  end
                  OP_TNAT: begin
                     s_d.pred = pset(s_q.pred, c, f1, !f1);
                  end
                  OP_FCLASS: begin
                     if (is_tok(fr1) && c.cls[0]) begin
                        s_d.pred = pset(s_q.pred, c, 1'b1, 1'b0);
                     end else begin
                        s_d.pred = pcmp(s_q.pred, c, is_tok(fr1),
                                        c.cls[1] && fr1[63:0] == 64'h0);
                     end
                  end
                  OP_SPILL: begin
                     // flagged registers always store zero: one fixed choice
                     s_d.flag_collection_reg[idx] = f1;
                     s_d.mem_we    = 1'b1;
                     s_d.res       = {18'h00000, f1 ? 64'h0 : g1};
                  end
                  OP_FILL: begin
                     // 8-byte access only; no narrower fill exists
                     s_d.gr_dat[c.dst]  = d64;
                     s_d.gr_flag[c.dst] = s_q.flag_collection_reg[idx];
                  end
                  OP_FSPILL: begin
                     s_d.mem_we = 1'b1;
                     s_d.res    = fr1;
                  end
                  OP_FFILL: begin
                     s_d.fr[fd] = s_q.opd;
                  end
                  OP_SETF: begin
                     s_d.fr[fd] = f1 ? `CSU_FR_TOKEN : int_fr(g1);
                  end
                  OP_GETF: begin
                     s_d.gr_flag[c.dst] = is_tok(fr1);
                     s_d.gr_dat[c.dst]  = is_tok(fr1) ? 64'h0 : fr1[63:0];
                  end
                  default: begin
                     s_d.cmd = c;
                  end
               endcase
            end
            `CSU_OFS_ADDR:    s_d.addr = be_merge(s_q.addr, AVS_WRITEDATA, AVS_BYTEENABLE);
            `CSU_OFS_OPD_LO:  s_d.opd[31:0] = be_merge(s_q.opd[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
            `CSU_OFS_OPD_HI:  s_d.opd[63:32] = be_merge(s_q.opd[63:32], AVS_WRITEDATA, AVS_BYTEENABLE);
            `CSU_OFS_OPD_EX: begin
               wv             = be_merge({14'h0000, s_q.opd[81:64]}, AVS_WRITEDATA, AVS_BYTEENABLE);
               s_d.opd[81:64] = wv[17:0];
            end
            `CSU_OFS_STAT: begin
               // write one to clear the sticky faults
               if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`CSU_ST_CFAULT]) begin
                  s_d.cfault = 1'b0;
               end
               if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`CSU_ST_LFAULT]) begin
                  s_d.lfault = 1'b0;
               end
            end
            // software owns saving and restoring the collection register
            `CSU_OFS_FLAG_COLLECTION_REG_LO: s_d.flag_collection_reg[31:0] = be_merge(s_q.flag_collection_reg[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
            `CSU_OFS_FLAG_COLLECTION_REG_HI: s_d.flag_collection_reg[63:32] = be_merge(s_q.flag_collection_reg[63:32], AVS_WRITEDATA, AVS_BYTEENABLE);
            `CSU_OFS_PRED: begin
               wv       = be_merge({16'h0000, s_q.pred}, AVS_WRITEDATA, AVS_BYTEENABLE);
               s_d.pred = {wv[15:1], 1'b1};
            end
            `CSU_OFS_VSEL: begin
               if (AVS_BYTEENABLE[0]) begin
                  s_d.vsel = AVS_WRITEDATA[3:0];
               end
            end
            default: begin
               s_d.vsel = s_q.vsel;
            end
         endcase
      end
   end

   // ==================================================
   // state register
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s_q      <= '0;
         s_q.wt   <= 1'b1;
         s_q.pred <= `CSU_PRED_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign AVS_READDATA    = s_q.rdata;
   assign AVS_WAITREQUEST = s_q.wt;
   assign CONSUME_FAULT   = s_q.cfault;
endmodule : csu_top

// File: verilog/csu_defines.svh
// register offsets, field positions, reset values and fixed values of the speculation unit
// assumes a 32-bit avalon slave port with byte addresses
`ifndef CSU_DEFINES_SVH
`define CSU_DEFINES_SVH
// ==================================================
// register offsets (byte addresses)
`define CSU_OFS_CMD     6'h00
`define CSU_OFS_ADDR    6'h04
`define CSU_OFS_OPD_LO  6'h08
`define CSU_OFS_OPD_HI  6'h0c
`define CSU_OFS_OPD_EX  6'h10
`define CSU_OFS_STAT    6'h14
`define CSU_OFS_RES_LO  6'h18
`define CSU_OFS_RES_HI  6'h1c
`define CSU_OFS_RES_EX  6'h20
`define CSU_OFS_FLAG_COLLECTION_REG_LO 6'h24
`define CSU_OFS_FLAG_COLLECTION_REG_HI 6'h28
`define CSU_OFS_PRED    6'h2c
`define CSU_OFS_VSEL    6'h30
`define CSU_OFS_VLO     6'h34
`define CSU_OFS_VHI     6'h38
`define CSU_OFS_VFLG    6'h3c
// ==================================================
// status bits
`define CSU_ST_CFAULT 0
`define CSU_ST_LFAULT 1
`define CSU_ST_TAKEN  2
`define CSU_ST_MEMWE  3
// ==================================================
// fixed values
`define CSU_NGR        16
`define CSU_NFR        8
`define CSU_IDX_HI     8
`define CSU_IDX_LO     3
`define CSU_FR_TOKEN   82'h1fffe0000000000000000
`define CSU_FR_EXP_INT 17'h1003e
`define CSU_BUNDLE     32'h0000_0010
`define CSU_PRED_RST   16'h0001
`endif

// File: verilog/csu_pkg.sv
// types of the control speculation unit
// assumes csu_defines.svh is on the include path
package csu_pkg;
   // ==================================================
   // operation codes carried in the command word
   typedef enum logic [4:0] {
      OP_LD     = 5'h00, OP_LD_S   = 5'h01,
      OP_LDF    = 5'h02, OP_LDF_S  = 5'h03,
      OP_LDFP   = 5'h04, OP_LDFP_S = 5'h05,
      OP_ADD    = 5'h06, OP_ST     = 5'h07,
      OP_CHK    = 5'h08, OP_CMP    = 5'h09,
      OP_FCMP   = 5'h0a, OP_TNAT   = 5'h0b,
      OP_FCLASS = 5'h0c, OP_SPILL  = 5'h0d,
      OP_FILL   = 5'h0e, OP_FSPILL = 5'h0f,
      OP_FFILL  = 5'h10, OP_SETF   = 5'h11,
      OP_GETF   = 5'h12
   } csu_op_e;
   // ==================================================
   // command word layout
   typedef struct packed {
      logic [1:0] cls;    // fclass mask: [0] token, [1] zero
      logic       w32;    // int32_compare: low 32 bits only
      logic       ctype;  // 0 clearing type, 1 or type
      logic [3:0] p2;
      logic [3:0] p1;
      logic [3:0] s2;
      logic [3:0] s1;
      logic [3:0] dst;
      logic [1:0] rsv;
      logic       flt;    // memory access of a load would fault
      csu_op_e    op;
   } csu_cmd_s;
   // ==================================================
   // whole state of the unit
   typedef struct packed {
      logic              wt;
      logic [31:0]       rdata;
      csu_cmd_s          cmd;
      logic [31:0]       addr;
      logic [81:0]       opd;
      logic [81:0]       res;
      logic [63:0]       flag_collection_reg;
      logic [15:0]       pred;
      logic [3:0]        vsel;
      logic              cfault;
      logic              lfault;
      logic              taken;
      logic              mem_we;
      logic [15:0][63:0] gr_dat;
      logic [15:0]       gr_flag;
      logic [7:0][81:0]  fr;
   } csu_state_s;
endpackage : csu_pkg

// File: bench/csu_top_monitor.sv
// checker of bus timing and fault pin of the speculation unit
// assumes it is bound to csu_top and sees only its ports
`timescale 1ns/1ps
`include "csu_defines.svh"
module csu_top_monitor (
   input wire logic        CLK,
   input wire logic        RESET,
   input wire logic [5:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        CONSUME_FAULT
);
   // accepted transfers, decoded once for all properties
   logic rd_acc;
   logic wr_cmd;
   logic wr_clr;
   assign rd_acc = AVS_READ && !AVS_WAITREQUEST;
   assign wr_cmd = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `CSU_OFS_CMD;
   assign wr_clr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `CSU_OFS_STAT && AVS_WRITEDATA[0]
                   && AVS_BYTEENABLE[0];
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // ====================
   // handshake: exactly one wait cycle, low for one cycle only
   AST_ONE_WAIT: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request not answered after one wait cycle");
   AST_WAIT_PULSE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   AST_WAIT_CAUSE: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
      else $error("waitrequest low without a request");
   AST_RST_IDLE: assert property ($past(RESET) |-> AVS_WAITREQUEST && !CONSUME_FAULT && AVS_READDATA == 32'h0)
      else $error("outputs not idle after reset");
   // ====================
   // read values fixed by the register map
   AST_UNMAPPED: assert property (rd_acc && AVS_ADDRESS[1:0] != 2'h0 |-> AVS_READDATA == 32'h0)
      else $error("unaligned read returned data");
   AST_PRED_ONE: assert property (rd_acc && AVS_ADDRESS == `CSU_OFS_PRED |-> AVS_READDATA[0])
      else $error("predicate zero read as zero");
   AST_FLAG_BIT: assert property (rd_acc && AVS_ADDRESS == `CSU_OFS_VFLG |-> AVS_READDATA[31:1] == 31'h0)
      else $error("flag view wider than one bit");
   // ====================
   // fault pin moves only on a command or on a clearing write
   AST_FAULT_RISE: assert property ($rose(CONSUME_FAULT) |-> $past(wr_cmd) || $past(wr_cmd, 2))
      else $error("fault raised without a command");
   AST_FAULT_HOLD: assert property ($fell(CONSUME_FAULT) && !$past(RESET) |-> $past(wr_clr) || $past(wr_clr, 2))
      else $error("fault dropped without a clearing write");
   cover property (wr_cmd);
   cover property ($rose(CONSUME_FAULT));
   cover property (rd_acc && AVS_ADDRESS == `CSU_OFS_VFLG && AVS_READDATA[0]);
endmodule : csu_top_monitor

bind csu_top csu_top_monitor u_csu_top_monitor (.CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONSUME_FAULT(CONSUME_FAULT));

// File: bench/csu_top_tb_top.sv
// self-checking bench of the speculation unit over its avalon port
// assumes csu_pkg and csu_defines.svh are compiled and on the path
`timescale 1ns/1ps
`include "csu_defines.svh"
module csu_top_tb_top;
   import csu_pkg::*;
   logic        clk;
   logic        reset;
   logic        avs_read;
   logic        avs_write;
   logic        wt;
   logic        cf;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata;
   logic [31:0] rdata;
   logic [31:0] rd;
   int          fail_count;
   int          n_tests;
   // ====================
   // clock and device
   initial clk = 1'b0;
   always #5 clk = ~clk;
   csu_top u_csu_top (.CLK(clk), .RESET(reset), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(wt), .CONSUME_FAULT(cf));
   // ====================
   // shared tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   // one bus cycle; request held until waitrequest is sampled low
   task xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 50);
      if (n >= 50) begin
         // a hung handshake counts as a mismatch and ends the run
         fail_count++;
         summarize();
      end
      rd = rdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // one idle edge so that the next call never re-raises a strobe in this time step
      @(posedge clk);
   endtask : xfer
   task wr(input logic [5:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task chk_rd(input logic [5:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : chk_rd
   task op(input csu_op_e o, input int d, input int s1, input int s2, input int p1, input int p2,
           input int hi, input int f);
      wr(`CSU_OFS_CMD, {hi[3:0], p2[3:0], p1[3:0], s2[3:0], s1[3:0], d[3:0], 2'h0, f[0], o});
   endtask : op
   // flag of one general register through the view window
   task flag(input int idx, input logic [31:0] exp);
      wr(`CSU_OFS_VSEL, {28'h0, idx[3:0]});
      chk_rd(`CSU_OFS_VFLG, exp);
   endtask : flag
   // ====================
   // scenarios
   task t_reset;
      chk_rd(`CSU_OFS_PRED, 32'h1);
      chk_rd(`CSU_OFS_STAT, 32'h0);
      wr(6'h05, 32'hffff_ffff);
      chk_rd(6'h05, 32'h0);
      wr(`CSU_OFS_RES_LO, 32'h1234);
      chk_rd(`CSU_OFS_RES_LO, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_load;
      wr(`CSU_OFS_OPD_LO, 32'hdead_beef);
      wr(`CSU_OFS_OPD_HI, 32'h0123_4567);
      op(OP_LD, 3, 0, 0, 0, 0, 0, 0);
      flag(3, 32'h0);
      chk_rd(`CSU_OFS_VLO, 32'hdead_beef);
      chk_rd(`CSU_OFS_VHI, 32'h0123_4567);
      op(OP_LD_S, 1, 0, 0, 0, 0, 0, 1);
      flag(1, 32'h1);
      chk_rd(`CSU_OFS_STAT, 32'h0);
      op(OP_LD, 2, 0, 0, 0, 0, 0, 1);
      chk_rd(`CSU_OFS_STAT, 32'h2);
      flag(2, 32'h0);
      wr(`CSU_OFS_STAT, 32'h2);
      op(OP_LDF_S, 0, 0, 0, 0, 0, 0, 1);
      op(OP_GETF, 9, 1, 0, 0, 0, 0, 0);
      flag(9, 32'h0);
      op(OP_LDF_S, 1, 0, 0, 0, 0, 0, 1);
      op(OP_GETF, 9, 1, 0, 0, 0, 0, 0);
      flag(9, 32'h1);
      $display("test load done");
   endtask : t_load
   task t_prop;
      op(OP_ADD, 4, 3, 1, 0, 0, 0, 0);
      flag(4, 32'h1);
      op(OP_ADD, 5, 3, 3, 0, 0, 0, 1);
      flag(5, 32'h0);
      chk_rd(`CSU_OFS_STAT, 32'h0);
      $display("test propagate done");
   endtask : t_prop
   task t_chk;
      wr(`CSU_OFS_ADDR, 32'h1000);
      wr(`CSU_OFS_OPD_LO, 32'h40);
      op(OP_CHK, 0, 1, 0, 0, 0, 0, 0);
      chk_rd(`CSU_OFS_STAT, 32'h4);
      chk_rd(`CSU_OFS_RES_LO, 32'h1040);
      op(OP_CHK, 0, 3, 0, 0, 0, 0, 0);
      chk_rd(`CSU_OFS_STAT, 32'h0);
      chk_rd(`CSU_OFS_RES_LO, 32'h1000 + `CSU_BUNDLE);
      $display("test check done");
   endtask : t_chk
   task t_cmp;
      wr(`CSU_OFS_PRED, 32'h6);
      op(OP_CMP, 0, 1, 3, 1, 2, 1, 0);
      chk_rd(`CSU_OFS_PRED, 32'h7);
      op(OP_CMP, 0, 1, 3, 1, 2, 0, 0);
      chk_rd(`CSU_OFS_PRED, 32'h1);
      op(OP_TNAT, 0, 1, 0, 3, 4, 0, 0);
      chk_rd(`CSU_OFS_PRED, 32'h9);
      op(OP_SETF, 0, 1, 0, 0, 0, 0, 0);
      wr(`CSU_OFS_PRED, 32'h60);
      op(OP_FCMP, 0, 0, 0, 5, 6, 0, 0);
      chk_rd(`CSU_OFS_PRED, 32'h1);
      op(OP_FCLASS, 0, 0, 0, 5, 6, 4, 0);
      chk_rd(`CSU_OFS_PRED, 32'h21);
      $display("test compare done");
   endtask : t_cmp
   task t_fault;
      op(OP_ST, 0, 3, 1, 0, 0, 0, 0);
      repeat (2) @(posedge clk);
      check({31'h0, cf}, 32'h1);
      chk_rd(`CSU_OFS_STAT, 32'h1);
      wr(`CSU_OFS_STAT, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, cf}, 32'h0);
      $display("test fault done");
   endtask : t_fault
   task t_spill;
      wr(`CSU_OFS_ADDR, 32'h1a8);
      op(OP_SPILL, 0, 1, 0, 0, 0, 0, 0);
      chk_rd(`CSU_OFS_FLAG_COLLECTION_REG_HI, 32'h0020_0000);
      chk_rd(`CSU_OFS_RES_LO, 32'h0);
      chk_rd(`CSU_OFS_STAT, 32'h8);
      wr(`CSU_OFS_FLAG_COLLECTION_REG_LO, 32'h2);
      wr(`CSU_OFS_ADDR, 32'h8);
      op(OP_SPILL, 0, 3, 0, 0, 0, 0, 0);
      chk_rd(`CSU_OFS_FLAG_COLLECTION_REG_LO, 32'h0);
      chk_rd(`CSU_OFS_RES_LO, 32'hdead_beef);
      chk_rd(`CSU_OFS_RES_HI, 32'h0123_4567);
      wr(`CSU_OFS_OPD_LO, 32'h55);
      wr(`CSU_OFS_ADDR, 32'h1a8);
      op(OP_FILL, 6, 0, 0, 0, 0, 0, 0);
      flag(6, 32'h1);
      wr(`CSU_OFS_ADDR, 32'h8);
      op(OP_FILL, 7, 0, 0, 0, 0, 0, 0);
      flag(7, 32'h0);
      chk_rd(`CSU_OFS_VLO, 32'h55);
      $display("test spill done");
   endtask : t_spill
   task t_fp;
      op(OP_FSPILL, 0, 0, 0, 0, 0, 0, 0);
      chk_rd(`CSU_OFS_RES_EX, 32'h1fffe);
      chk_rd(`CSU_OFS_STAT, 32'h8);
      chk_rd(`CSU_OFS_FLAG_COLLECTION_REG_HI, 32'h0020_0000);
      op(OP_GETF, 8, 0, 0, 0, 0, 0, 0);
      flag(8, 32'h1);
      op(OP_FFILL, 2, 0, 0, 0, 0, 0, 0);
      op(OP_FSPILL, 0, 2, 0, 0, 0, 0, 0);
      chk_rd(`CSU_OFS_RES_LO, 32'h55);
      chk_rd(`CSU_OFS_RES_HI, 32'h0123_4567);
      op(OP_LDFP_S, 4, 0, 0, 0, 0, 0, 1);
      op(OP_GETF, 10, 5, 0, 0, 0, 0, 0);
      flag(10, 32'h1);
      $display("test float done");
   endtask : t_fp
   // ====================
   // verdict, reached from the end of the tests, a hung handshake in xfer or the watchdog
   task summarize;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #50000;
      fail_count++;
      summarize();
   end
   // main sequence
   initial begin
      fail_count = 0;
      n_tests = 0;
      reset = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_load();
      t_prop();
      t_chk();
      t_cmp();
      t_fault();
      t_spill();
      t_fp();
      summarize();
   end
endmodule : csu_top_tb_top
